// file: mmdt_pkg.sv
package mmdt_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_SET = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;

    // setting register fields
    localparam int SET_MODE_LSB = 0;
    localparam int SET_UNIT_LSB = 4;
    localparam int SET_PRESET_LSB = 8;

    // status register fields
    localparam int STAT_RELAY = 0;
    localparam int STAT_TIMEOUT = 1;
    localparam int STAT_BUSY = 2;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_UNIT_LSB = 8;
    localparam int STAT_REM_LSB = 16;

    typedef logic [2:0] mmdt_mode_t;
    typedef logic [2:0] mmdt_unit_t;
    typedef logic [9:0] mmdt_count_t;

    // the eight operating modes
    localparam mmdt_mode_t MODE_ON_DELAY = 3'h0;
    localparam mmdt_mode_t MODE_FLICKER = 3'h1;
    localparam mmdt_mode_t MODE_SIG_ONOFF1 = 3'h2;
    localparam mmdt_mode_t MODE_SIG_OFF1 = 3'h3;
    localparam mmdt_mode_t MODE_INTERVAL = 3'h4;
    localparam mmdt_mode_t MODE_ONESHOT_FLK = 3'h5;
    localparam mmdt_mode_t MODE_SIG_ONOFF2 = 3'h6;
    localparam mmdt_mode_t MODE_SIG_OFF2 = 3'h7;

    // the seven time units; code 7 is unused and behaves as seconds
    localparam mmdt_unit_t UNIT_TENTH_S = 3'h0;
    localparam mmdt_unit_t UNIT_S = 3'h1;
    localparam mmdt_unit_t UNIT_TENTH_MIN = 3'h2;
    localparam mmdt_unit_t UNIT_MIN = 3'h3;
    localparam mmdt_unit_t UNIT_TENTH_H = 3'h4;
    localparam mmdt_unit_t UNIT_H = 3'h5;
    localparam mmdt_unit_t UNIT_TEN_H = 3'h6;

    // preset limits and reset values
    localparam mmdt_count_t PRESET_MAX = 10'h3E7;
    localparam mmdt_count_t PRESET_RST = 10'h001;
    localparam mmdt_mode_t MODE_RST = MODE_ON_DELAY;
    localparam mmdt_unit_t UNIT_RST = UNIT_S;

    // timebase: one tenth of a second counted on the 10 MHz bus clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int TENTH_S_NS = 100000000;
    localparam int TENTH_CYC = TENTH_S_NS / CLK_PERIOD_NS;
    // shortest input pulse the far side must give; shorter ones may be missed
    localparam int MIN_PULSE_NS = 50000000;

    localparam int UDIV_W = 19;

    // tenths of a second per time unit
    function automatic logic [UDIV_W-1:0] unit_mult(input mmdt_unit_t u);
        case (u)
            UNIT_TENTH_S: unit_mult = 19'h00001;
            UNIT_S: unit_mult = 19'h0000A;
            UNIT_TENTH_MIN: unit_mult = 19'h0003C;
            UNIT_MIN: unit_mult = 19'h00258;
            UNIT_TENTH_H: unit_mult = 19'h00E10;
            UNIT_H: unit_mult = 19'h08CA0;
            UNIT_TEN_H: unit_mult = 19'h57E40;
            default: unit_mult = 19'h0000A;
        endcase
    endfunction : unit_mult

    typedef enum {ST_IDLE, ST_HOLD, ST_TIMING, ST_DONE} mmdt_state_e;

endpackage : mmdt_pkg

// file: mmdt_tick_if.sv
`timescale 1ns/1ps
interface mmdt_tick_if;
    import mmdt_pkg::*;
    logic clear;
    logic run;
    mmdt_unit_t unit;
    logic tick;
    modport gen (input clear, input run, input unit, output tick);
    modport user (output clear, output run, output unit, input tick);
endinterface : mmdt_tick_if

// file: mmdt_tick.sv
`timescale 1ns/1ps
module mmdt_tick #(
    parameter int TENTH_CYCLES = mmdt_pkg::TENTH_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // timebase link to the sequencer
    mmdt_tick_if.gen tk
);
    import mmdt_pkg::*;

    localparam int PRE_W = 24;

    initial begin
        if (TENTH_CYCLES < 1 || TENTH_CYCLES >= (1 << PRE_W)) begin
            $error("mmdt_tick: TENTH_CYCLES out of range");
        end
    end

    logic [PRE_W-1:0] pre;
    logic [UDIV_W-1:0] ucnt;
    logic tenth_end;
    logic unit_end;

    assign tenth_end = (pre == PRE_W'(TENTH_CYCLES - 1));
    assign unit_end = (ucnt == unit_mult(tk.unit) - 19'h00001);
    // one pulse per selected unit, only while the sequencer lets time run
    assign tk.tick = tk.run && tenth_end && unit_end;

    // tenth-second prescaler; it freezes while paused, keeping the fraction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre <= '0;
        end else if (tk.clear) begin
            pre <= '0;
        end else if (tk.run) begin
            pre <= tenth_end ? '0 : pre + PRE_W'(1);
        end
    end

    // unit divider in tenths of a second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ucnt <= '0;
        end else if (tk.clear) begin
            ucnt <= '0;
        end else if (tk.run && tenth_end) begin
            ucnt <= unit_end ? '0 : ucnt + 19'h00001;
        end
    end

    property p_tick_paced;
        @(posedge hclk) disable iff (!hresetn)
        tk.tick |=> pre == '0 && ucnt == '0;
    endproperty
    a_tick_paced: assert property (p_tick_paced)
        else $error("tick fired before a full unit");

endmodule : mmdt_tick

// file: mmdt_timer.sv
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module mmdt_timer #(
    parameter int TENTH_CYCLES = mmdt_pkg::TENTH_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // supply sense, active high, and signal inputs, active low
    input wire logic power_on,
    input wire logic start_n,
    input wire logic reset_n,
    input wire logic gate_n,
    input wire logic check_n,
    // outputs
    output logic relay_out,
    output logic timeout_ind,
    output mmdt_pkg::mmdt_count_t remain_ind
);
    import mmdt_pkg::*;

    initial begin
        if (TENTH_CYCLES < 1) begin
            $error("mmdt_timer: TENTH_CYCLES must be positive");
        end
    end

    mmdt_tick_if tk ();

    mmdt_tick #(.TENTH_CYCLES(TENTH_CYCLES)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tk(tk)
    );

    // ---- bus slave ----
    logic wr_pend;
    logic [7:0] addr_q;
    mmdt_mode_t sw_mode;
    mmdt_unit_t sw_unit;
    mmdt_count_t sw_preset;
    logic acc;
    logic [31:0] stat_word;
    logic [31:0] set_word;
    mmdt_count_t wr_preset;

    // ---- sequencer ----
    mmdt_state_e st;
    mmdt_mode_t cfg_mode;
    mmdt_unit_t cfg_unit;
    mmdt_count_t cfg_preset;
    mmdt_count_t elapsed;
    logic out_r;
    logic reload;
    logic pwr_q, start_q, check_q;
    logic start_act, reset_act, gate_act, check_act;
    logic start_on, start_off, check_on, pwr_rise;
    logic rst_evt, go, trig, zero, last_unit, expire;
    logic pwr_mode, sig_mode, hold_mode, mask_mode;

    // never stalls, never errors: every register answers in zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign acc = hsel && htrans[1] && hready;

    // address phase capture; only word accesses are supported
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend <= acc && hwrite;
            addr_q <= haddr[7:0];
        end
    end

    // larger presets clamp so the count never passes three digits
    assign wr_preset = (hwdata[SET_PRESET_LSB +: 10] > PRESET_MAX) ? PRESET_MAX
                     : hwdata[SET_PRESET_LSB +: 10];

    // setting register written in the data phase; unmapped writes are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_mode <= MODE_RST;
            sw_unit <= UNIT_RST;
            sw_preset <= PRESET_RST;
        end else if (wr_pend && addr_q == OFF_SET) begin
            sw_mode <= hwdata[SET_MODE_LSB +: 3];
            sw_unit <= hwdata[SET_UNIT_LSB +: 3];
            sw_preset <= wr_preset;
        end
    end

    always_comb begin
        set_word = 32'h0000_0000;
        set_word[SET_MODE_LSB +: 3] = sw_mode;
        set_word[SET_UNIT_LSB +: 3] = sw_unit;
        set_word[SET_PRESET_LSB +: 10] = sw_preset;
        stat_word = 32'h0000_0000;
        stat_word[STAT_RELAY] = relay_out;
        stat_word[STAT_TIMEOUT] = timeout_ind;
        stat_word[STAT_BUSY] = (st != ST_IDLE);
        stat_word[STAT_MODE_LSB +: 3] = cfg_mode;
        stat_word[STAT_UNIT_LSB +: 3] = cfg_unit;
        stat_word[STAT_REM_LSB +: 10] = remain_ind;
    end

    // read data is loaded at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                OFF_SET: hrdata <= set_word;
                OFF_STAT: hrdata <= stat_word;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ---- input conditioning ----
    // pins are active low, so a falling level is the assertion
    assign start_act = !start_n;
    assign reset_act = !reset_n;
    assign gate_act = !gate_n;
    assign check_act = !check_n;

    // previous levels for edge detection; inputs are already synchronous
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_q <= 1'b0;
            start_q <= 1'b0;
            check_q <= 1'b0;
        end else begin
            pwr_q <= power_on;
            start_q <= start_act;
            check_q <= check_act;
        end
    end

    assign start_on = start_act && !start_q;
    assign start_off = !start_act && start_q;
    assign check_on = check_act && !check_q;
    assign pwr_rise = power_on && !pwr_q;
    // reset pin and loss of power both reset, and win over any start
    assign rst_evt = reset_act || !power_on;

    // mode groups
    assign pwr_mode = (cfg_mode == MODE_ON_DELAY) || (cfg_mode == MODE_FLICKER)
                   || (cfg_mode == MODE_INTERVAL) || (cfg_mode == MODE_ONESHOT_FLK);
    assign sig_mode = (cfg_mode == MODE_SIG_ONOFF1) || (cfg_mode == MODE_SIG_ONOFF2);
    assign hold_mode = (cfg_mode == MODE_SIG_OFF1) || (cfg_mode == MODE_SIG_OFF2);
    assign mask_mode = (cfg_mode == MODE_SIG_ONOFF2) || (cfg_mode == MODE_SIG_OFF2);

    // power-up or the start pin launches the power-started modes
    assign go = pwr_rise || start_on;
    assign trig = go || start_off;
    assign zero = (cfg_preset == 10'h000);
    assign last_unit = (elapsed + 10'h001 >= cfg_preset);
    // check jumps straight to the end; a zero preset expires at once
    assign expire = (st == ST_TIMING)
                 && (check_on || zero || (tk.tick && last_unit));

    // settings are sampled while idle and not about to leave idle, and on any reset event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_mode <= MODE_RST;
            cfg_unit <= UNIT_RST;
            cfg_preset <= PRESET_RST;
        end else if (rst_evt || (st == ST_IDLE && !trig)) begin
            cfg_mode <= sw_mode;
            cfg_unit <= sw_unit;
            cfg_preset <= sw_preset;
        end
    end

    // timebase runs only while timing, gate and check both released
    assign tk.run = (st == ST_TIMING) && !gate_act && !check_act;
    assign tk.clear = (st != ST_TIMING) || reload;
    assign tk.unit = cfg_unit;

    // elapsed count; a pause leaves it untouched so both halves add up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            elapsed <= 10'h000;
        end else if (st != ST_TIMING || reload || expire) begin
            elapsed <= 10'h000;
        end else if (tk.tick) begin
            elapsed <= elapsed + 10'h001;
        end
    end

    // main sequencer: one branch per state, mode decides the path
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= ST_IDLE;
            out_r <= 1'b0;
            reload <= 1'b0;
            timeout_ind <= 1'b0;
        end else if (rst_evt) begin
            st <= ST_IDLE;
            out_r <= 1'b0;
            reload <= 1'b0;
            timeout_ind <= 1'b0;
        end else begin
            reload <= 1'b0;
            case (st)
                ST_IDLE: begin
                    if (pwr_mode && go && !(zero && cfg_mode != MODE_INTERVAL)) begin
                        st <= ST_TIMING;
                        // flicker and on-delay start off, the others start energised
                        out_r <= (cfg_mode != MODE_FLICKER && cfg_mode != MODE_ON_DELAY);
                    end else if (sig_mode && (start_on || start_off)) begin
                        st <= ST_TIMING;
                        out_r <= 1'b1;
                    end else if (hold_mode && start_on) begin
                        st <= ST_HOLD;
                        out_r <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    // off-delay time begins when the start signal drops
                    if (start_off) begin
                        st <= ST_TIMING;
                    end
                end
                ST_TIMING: begin
                    if (expire) begin
                        timeout_ind <= 1'b1;
                        case (cfg_mode)
                            MODE_ON_DELAY: begin
                                st <= ST_DONE;
                                out_r <= 1'b1;
                            end
                            MODE_FLICKER, MODE_ONESHOT_FLK: begin
                                out_r <= !out_r;
                            end
                            default: begin
                                st <= ST_DONE;
                                out_r <= 1'b0;
                            end
                        endcase
                    end else if (sig_mode && (start_on || start_off)) begin
                        reload <= 1'b1;
                        out_r <= 1'b1;
                    end else if (hold_mode && start_on) begin
                        st <= ST_HOLD;
                    end else if (cfg_mode == MODE_INTERVAL && start_on) begin
                        reload <= 1'b1;
                    end
                end
                ST_DONE: begin
                    if (sig_mode && (start_on || start_off)) begin
                        st <= ST_TIMING;
                        out_r <= 1'b1;
                        timeout_ind <= 1'b0;
                    end else if (hold_mode && start_on) begin
                        st <= ST_HOLD;
                        out_r <= 1'b1;
                        timeout_ind <= 1'b0;
                    end else if (cfg_mode == MODE_INTERVAL && go) begin
                        st <= ST_TIMING;
                        out_r <= 1'b1;
                        timeout_ind <= 1'b0;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end

    // relay is registered; the second signal variants hold it off during start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_out <= 1'b0;
        end else begin
            relay_out <= out_r && !(mask_mode && start_act) && !rst_evt;
        end
    end

    // remaining time: full while idle or holding, empty once done
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain_ind <= 10'h000;
        end else begin
            case (st)
                ST_IDLE, ST_HOLD: remain_ind <= cfg_preset;
                ST_TIMING: remain_ind <= cfg_preset - elapsed;
                ST_DONE: remain_ind <= 10'h000;
                default: remain_ind <= 10'h000;
            endcase
        end
    end

    // ---- checks ----
    property p_reset_prio;
        @(posedge hclk) disable iff (!hresetn)
        reset_act && start_act |=> st == ST_IDLE && !out_r ##1 !relay_out;
    endproperty
    a_reset_prio: assert property (p_reset_prio)
        else $error("start beat reset");

    property p_gate_pause;
        @(posedge hclk) disable iff (!hresetn)
        st == ST_TIMING && gate_act && !rst_evt && !expire && !reload
            |=> elapsed == $past(elapsed);
    endproperty
    a_gate_pause: assert property (p_gate_pause)
        else $error("elapsed time moved while gated");

    property p_check_jump;
        @(posedge hclk) disable iff (!hresetn)
        st == ST_TIMING && check_on && !rst_evt |=> timeout_ind && elapsed == 10'h000;
    endproperty
    a_check_jump: assert property (p_check_jump)
        else $error("check did not end the interval");

    property p_check_hold;
        @(posedge hclk) disable iff (!hresetn)
        check_act |-> !tk.tick;
    endproperty
    a_check_hold: assert property (p_check_hold)
        else $error("time counted while check held");

    property p_mask_start;
        @(posedge hclk) disable iff (!hresetn)
        mask_mode && start_act |=> !relay_out;
    endproperty
    a_mask_start: assert property (p_mask_start)
        else $error("relay on while start held");

    property p_ondelay_out;
        @(posedge hclk) disable iff (!hresetn)
        cfg_mode == MODE_ON_DELAY && expire && !rst_evt |=> out_r && st == ST_DONE;
    endproperty
    a_ondelay_out: assert property (p_ondelay_out)
        else $error("on-delay expiry did not energise");

    property p_sig_edge;
        @(posedge hclk) disable iff (!hresetn)
        sig_mode && start_q != start_act && !rst_evt && !expire
            |=> out_r && st == ST_TIMING;
    endproperty
    a_sig_edge: assert property (p_sig_edge)
        else $error("signal edge did not start timing");

    property p_zero_quiet;
        @(posedge hclk) disable iff (!hresetn)
        st == ST_IDLE && zero && (cfg_mode == MODE_ON_DELAY || cfg_mode == MODE_FLICKER
            || cfg_mode == MODE_ONESHOT_FLK) |=> st == ST_IDLE;
    endproperty
    a_zero_quiet: assert property (p_zero_quiet)
        else $error("zero preset started a power mode");

endmodule : mmdt_timer

// file: mmdt_contacts.sv
`timescale 1ns/1ps
// far-side switch contacts; an open contact lets its line rise to the pull-up
module mmdt_contacts (
    // clock
    input wire logic hclk,
    // closure request: check, gate, reset, start
    input wire logic [3:0] press,
    // signal lines to the timer, active low
    output logic start_n = 1'b1,
    output logic reset_n = 1'b1,
    output logic gate_n = 1'b1,
    output logic check_n = 1'b1
);
    // a closure pulls its own line low just after an edge
    always @(posedge hclk) begin
        start_n <= ~press[0];
        reset_n <= ~press[1];
        gate_n <= ~press[2];
        check_n <= ~press[3];
    end
endmodule : mmdt_contacts

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mmdt_pkg::*;
    localparam int TC = 10; // shortened tenth second keeps the run short
    typedef struct {mmdt_mode_t m; mmdt_count_t p; logic st; int lo, hi, lo2, hi2;} mmdt_row_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp;
    logic [31:0] hrdata, rd;
    logic power_on = 1'b0;
    logic [3:0] press = 4'h0;
    logic start_n, reset_n, gate_n, check_n, relay_out, timeout_ind, bad;
    mmdt_count_t remain_ind;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    // rising relay first, then its fall where hi2 is set
    mmdt_row_s rows [6] = '{
        '{MODE_ON_DELAY, 10'h003, 1'b0, 28, 35, 0, 0},
        '{MODE_FLICKER, 10'h002, 1'b0, 18, 25, 18, 24},
        '{MODE_ONESHOT_FLK, 10'h002, 1'b0, 0, 4, 18, 24},
        '{MODE_SIG_ONOFF1, 10'h002, 1'b1, 0, 4, 17, 25},
        '{MODE_SIG_OFF1, 10'h002, 1'b1, 0, 4, 17, 25},
        '{MODE_INTERVAL, 10'h002, 1'b0, 0, 4, 17, 25}};

    mmdt_timer #(.TENTH_CYCLES(TC)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .power_on(power_on), .start_n(start_n), .reset_n(reset_n), .gate_n(gate_n),
        .check_n(check_n), .relay_out(relay_out), .timeout_ind(timeout_ind),
        .remain_ind(remain_ind));
    mmdt_contacts part_u (.hclk(hclk), .press(press), .start_n(start_n),
        .reset_n(reset_n), .gate_n(gate_n), .check_n(check_n));

    initial begin
        forever #50 hclk = ~hclk;
    end
    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
    endtask : rng
    // one ahb-lite single transfer; hready is waited for, never assumed
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    function automatic logic [31:0] set_w(mmdt_mode_t m, mmdt_count_t p);
        return (32'(m) << SET_MODE_LSB) | (32'(UNIT_TENTH_S) << SET_UNIT_LSB)
            | (32'(p) << SET_PRESET_LSB);
    endfunction : set_w
    // settings are only taken while idle or on a reset event, so drop power around the write
    task automatic restart(input mmdt_mode_t m, input mmdt_count_t p);
        @(posedge hclk);
        power_on <= 1'b0;
        repeat (3) @(posedge hclk);
        bus(1'b1, OFF_SET, set_w(m, p));
        // the setting lands at the data-phase edge; let idle capture it first
        @(posedge hclk);
        power_on <= 1'b1;
    endtask : restart
    task automatic wait_lvl(input logic lvl, output int k);
        k = 0;
        @(negedge hclk);
        while (relay_out !== lvl && k < 300) begin
            @(negedge hclk);
            k = k + 1;
        end
    endtask : wait_lvl
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFF_SET, 32'h0);
        chk(rd, (32'(MODE_RST) << SET_MODE_LSB) | (32'(UNIT_RST) << SET_UNIT_LSB)
            | (32'(PRESET_RST) << SET_PRESET_LSB));
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        chk({relay_out, timeout_ind, hresp}, 3'h0);
        chk(remain_ind, PRESET_RST);
        $display("test reset done");
        foreach (rows[i]) begin
            restart(rows[i].m, rows[i].p);
            if (rows[i].st) press <= 4'h1;
            wait_lvl(1'b1, n);
            rng(n, rows[i].lo, rows[i].hi);
            if (rows[i].st) begin
                repeat (6) @(posedge hclk);
                press <= 4'h0;
            end
            if (rows[i].hi2 > 0) begin
                wait_lvl(1'b0, n);
                rng(n, rows[i].lo2, rows[i].hi2);
            end else begin
                chk(timeout_ind, 1'b1);
                chk(remain_ind, 10'h000);
            end
            $display("test row %0d done", i);
        end
        // gate pause keeps elapsed time
        restart(MODE_ON_DELAY, 10'h003);
        repeat (10) @(posedge hclk);
        press <= 4'h4;
        repeat (20) @(posedge hclk);
        press <= 4'h0;
        wait_lvl(1'b1, n);
        rng(n, 16, 24);
        $display("test gate done");
        // check forces expiry at once
        restart(MODE_ON_DELAY, 10'h009);
        repeat (10) @(posedge hclk);
        press <= 4'h8;
        wait_lvl(1'b1, n);
        rng(n, 0, 4);
        // reset wins over start, then start alone runs on-delay
        press <= 4'h2;
        wait_lvl(1'b0, n);
        rng(n, 0, 4);
        repeat (6) @(posedge hclk);
        press <= 4'h3;
        repeat (6) @(posedge hclk);
        press <= 4'h2;
        repeat (6) @(posedge hclk);
        press <= 4'h0;
        repeat (30) @(negedge hclk);
        chk(relay_out, 1'b0);
        press <= 4'h1;
        repeat (6) @(posedge hclk);
        press <= 4'h0;
        wait_lvl(1'b1, n);
        rng(n, 84, 90);
        $display("test check and reset done");
        // second signal variant keeps relay released while start is held
        restart(MODE_SIG_ONOFF2, 10'h002);
        press <= 4'h1;
        bad = 1'b0;
        repeat (30) @(negedge hclk) if (relay_out !== 1'b0) bad = 1'b1;
        chk(bad, 1'b0);
        press <= 4'h0;
        // zero preset: none in on-delay, output in signal off-delay
        restart(MODE_ON_DELAY, 10'h000);
        repeat (40) @(negedge hclk);
        chk(relay_out, 1'b0);
        restart(MODE_SIG_OFF1, 10'h000);
        press <= 4'h1;
        wait_lvl(1'b1, n);
        rng(n, 0, 4);
        press <= 4'h0;
        $display("test variants done");
        // settings written mid-run are ignored
        restart(MODE_ON_DELAY, 10'h003);
        repeat (5) @(posedge hclk);
        bus(1'b1, OFF_SET, set_w(MODE_ON_DELAY, 10'h009));
        bus(1'b0, OFF_STAT, 32'h0);
        chk(rd[STAT_BUSY], 1'b1);
        chk(rd[STAT_REM_LSB +: 10], 10'h003);
        wait_lvl(1'b1, n);
        rng(n, 15, 28);
        chk(remain_ind, 10'h000);
        $display("test frozen settings done");
        tally_and_finish();
    end
endmodule : tb_top
